// File: dcra_debug_register_access.sv
// Debug command interpreter for program counter and register file access.
// Assumes deframed bytes arrive on clk with valid/ready, and the register file
// returns read data in the cycle after its read strobe, holding it until the next.
`timescale 1ns/100ps
`default_nettype none
module dcra_debug_register_access
   import dcra_pkg::*;
#(
   parameter logic [11:0] FLASH_CTL_LO = 12'hff8,
   parameter logic [11:0] FLASH_CTL_HI = 12'hfff
)
(
   input wire logic clk,
   input wire logic reset_n,
   input wire logic rx_valid,
   input wire logic [7:0] rx_data,
   output logic rx_ready,
   output logic tx_valid,
   output logic [7:0] tx_data,
   input wire logic tx_ready,
   input wire logic read_protect,
   input wire logic [15:0] pc_value,
   output dcra_regport_type reg_port,
   input wire logic [7:0] reg_rdata,
   output logic debug_halt_control_bit,
   output logic [7:0] debug_control_register
);
   dcra_reg_type r_q;
   dcra_reg_type r_d;
   logic rx_take;
   logic tx_take;
   logic push;
   logic debug_mode;

   // A size byte of zero stands for a full 256-byte transfer
   function automatic logic [8:0] size_count(input logic [7:0] size);
      size_count = (size == 8'h00) ? FULL_SIZE : {1'b0, size};
   endfunction : size_count

   // Debug mode is the halt bit of the control register
   assign debug_mode = r_q.ctl[HALT_BIT];
   assign debug_halt_control_bit = r_q.ctl[HALT_BIT];
   assign debug_control_register = r_q.ctl;
   assign reg_port = r_q.port;
   assign tx_valid = r_q.bcnt != 2'h0;
   assign tx_data = r_q.buf_mem[r_q.rp];
   assign tx_take = tx_valid && tx_ready;
   // Buffer room is judged before the drain, so a full buffer never takes a byte
   assign push = (r_q.state == ST_PUSH) && (r_q.bcnt != BUF_DEPTH);
   assign rx_take = rx_valid && rx_ready;

   // Bytes are refused while an answer is being produced
   always_comb
   begin
      case (r_q.state)
         ST_IDLE, ST_CTL, ST_ADDR_HI, ST_ADDR_LO, ST_SIZE, ST_WDATA: rx_ready = 1'b1;
         default: rx_ready = 1'b0;
      endcase
   end

   always_comb
   begin
      r_d = r_q;
      // Strobes are one-cycle pulses unless a state raises them again
      r_d.port.we = 1'b0;
      r_d.port.re = 1'b0;
      case (r_q.state)
         ST_IDLE:
         begin
            if (rx_take)
            begin
               r_d.is_rd = rx_data == OP_RD_REG;
               r_d.is_pc = 1'b0;
               // Unknown opcodes are taken and dropped
               if (rx_data == OP_WR_CTL)
               begin
                  r_d.state = ST_CTL;
               end
               else if (rx_data == OP_RD_PC)
               begin
                  // Snapshot so both bytes come from one counter value
                  r_d.pc = (debug_mode && !read_protect) ? pc_value : PC_BLOCKED;
                  r_d.is_pc = 1'b1;
                  r_d.cnt = PC_BYTES;
                  r_d.data = (debug_mode && !read_protect) ? pc_value[15:8]
                                                          : PC_BLOCKED[15:8];
                  r_d.state = ST_PUSH;
               end
               else if (rx_data == OP_WR_REG || rx_data == OP_RD_REG)
               begin
                  r_d.state = ST_ADDR_HI;
               end
            end
         end
         ST_CTL:
         begin
            if (rx_take)
            begin
               // Other control bits write freely even under protection
               r_d.ctl = rx_data;
               if (read_protect && r_q.ctl[HALT_BIT])
               begin
                  r_d.ctl[HALT_BIT] = 1'b1;
               end
               r_d.state = ST_IDLE;
            end
         end
         ST_ADDR_HI:
         begin
            if (rx_take)
            begin
               // Upper nibble of this byte is zero by protocol and is not checked
               r_d.port.addr[11:8] = rx_data[3:0];
               r_d.state = ST_ADDR_LO;
            end
         end
         ST_ADDR_LO:
         begin
            if (rx_take)
            begin
               // Reads and writes share the same two address bytes
               r_d.port.addr[7:0] = rx_data;
               r_d.state = ST_SIZE;
            end
         end
         ST_SIZE:
         begin
            if (rx_take)
            begin
               r_d.cnt = size_count(rx_data);
               if (r_q.is_rd)
               begin
                  r_d.port.re = 1'b1;
                  r_d.state = ST_RD_WAIT;
               end
               else
               begin
                  // Preset one below the start; each taken data byte steps it first
                  r_d.port.addr = r_q.port.addr - 12'h001;
                  r_d.state = ST_WDATA;
               end
            end
         end
         ST_WDATA:
         begin
            if (rx_take)
            begin
               // Every taken byte steps the address, stored or dropped, so bytes stay aligned
               r_d.port.addr = r_q.port.addr + 12'h001;
               r_d.port.data = rx_data;
               r_d.port.we = debug_mode && (!read_protect
                  || (r_d.port.addr >= FLASH_CTL_LO && r_d.port.addr <= FLASH_CTL_HI));
               r_d.cnt = r_q.cnt - 9'h001;
               if (r_q.cnt == 9'h001)
               begin
                  r_d.state = ST_IDLE;
               end
            end
         end
         ST_RD_WAIT:
         begin
            // The file answers one cycle after the strobe
            r_d.state = ST_RD_CAP;
         end
         ST_RD_CAP:
         begin
            // Blocked reads still strobe the file; only the returned byte is masked
            r_d.data = (debug_mode && !read_protect) ? reg_rdata : BYTE_BLOCKED;
            r_d.state = ST_PUSH;
         end
         ST_PUSH:
         begin
            if (push)
            begin
               r_d.buf_mem[r_q.wp] = r_q.data;
               r_d.wp = ~r_q.wp;
               r_d.cnt = r_q.cnt - 9'h001;
               if (r_q.cnt == 9'h001)
               begin
                  r_d.state = ST_IDLE;
               end
               else if (r_q.is_pc)
               begin
                  r_d.data = r_q.pc[7:0];
               end
               else
               begin
                  r_d.port.addr = r_q.port.addr + 12'h001;
                  r_d.port.re = 1'b1;
                  r_d.state = ST_RD_WAIT;
               end
            end
         end
         default:
         begin
            r_d.state = ST_IDLE;
         end
      endcase
      // Read pointer follows the receiver, whatever the interpreter is doing
      if (tx_take)
      begin
         r_d.rp = ~r_q.rp;
      end
      // A stalled receiver leaves the buffer full and holds the interpreter in push
      case ({push, tx_take})
         2'b10: r_d.bcnt = r_q.bcnt + 2'h1;
         2'b01: r_d.bcnt = r_q.bcnt - 2'h1;
         default: r_d.bcnt = r_q.bcnt;
      endcase
   end

   // Reset leaves the core outside debug mode with nothing buffered
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         r_q <= '0;
         r_q.state <= ST_IDLE;
         r_q.ctl <= CTL_RESET;
      end
      else
      begin
         r_q <= r_d;
      end
   end
endmodule : dcra_debug_register_access
`default_nettype wire

// File: dcra_pkg.sv
// Constants, states and the state record of the debug command register-access block.
// Assumes a byte-level debug serial link already deframed on the system clock.
// Operation
// - Opcode 07H returns the 16-bit program counter as two bytes, upper byte first.
// - Outside debug mode or under read protection the program counter read returns FFFFH.
// - A register write moves 1 to 256 bytes, a size of zero meaning 256.
// - Outside debug mode a register write takes all its bytes but stores none.
// - Under read protection a register write stores only into the flash control registers.
// - A register read is 09H with the same address bytes and size, returning 1 to 256 bytes.
// - Outside debug mode or under read protection every register read byte is FFH.
// - Under read protection the debug halt control bit can be set but not cleared by command.
package dcra_pkg;
   localparam logic [7:0] OP_WR_CTL = 8'h04;
   localparam logic [7:0] OP_RD_PC = 8'h07;
   localparam logic [7:0] OP_WR_REG = 8'h08;
   localparam logic [7:0] OP_RD_REG = 8'h09;
   localparam logic [7:0] BYTE_BLOCKED = 8'hff;
   localparam logic [15:0] PC_BLOCKED = 16'hffff;
   localparam logic [7:0] CTL_RESET = 8'h00;
   localparam int HALT_BIT = 7;
   localparam logic [8:0] FULL_SIZE = 9'h100;
   localparam logic [8:0] PC_BYTES = 9'h002;
   localparam logic [1:0] BUF_DEPTH = 2'h2;

   typedef enum logic [8:0]
   {
      ST_IDLE = 9'b0_0000_0001,
      ST_CTL = 9'b0_0000_0010,
      ST_ADDR_HI = 9'b0_0000_0100,
      ST_ADDR_LO = 9'b0_0000_1000,
      ST_SIZE = 9'b0_0001_0000,
      ST_WDATA = 9'b0_0010_0000,
      ST_RD_WAIT = 9'b0_0100_0000,
      ST_RD_CAP = 9'b0_1000_0000,
      ST_PUSH = 9'b1_0000_0000
   } dcra_state_type;

   typedef struct packed
   {
      logic [11:0] addr;
      logic [7:0] data;
      logic we;
      logic re;
   } dcra_regport_type;

   typedef struct packed
   {
      dcra_state_type state;
      logic is_rd;
      logic is_pc;
      logic [8:0] cnt;
      logic [15:0] pc;
      logic [7:0] data;
      logic [7:0] ctl;
      dcra_regport_type port;
      logic [1:0][7:0] buf_mem;
      logic wp;
      logic rp;
      logic [1:0] bcnt;
   } dcra_reg_type;
endpackage : dcra_pkg

// File: dcra_asserts.sv
// Checker for the debug register-access block.
// Bound to the block; sees only its ports.
`timescale 1ns/100ps
`default_nettype none
module dcra_asserts
   import dcra_pkg::*;
#(
   parameter logic [11:0] FLASH_CTL_LO = 12'hff8,
   parameter logic [11:0] FLASH_CTL_HI = 12'hfff
)
(
   input wire logic clk,
   input wire logic reset_n,
   input wire logic rx_ready,
   input wire logic tx_valid,
   input wire logic [7:0] tx_data,
   input wire logic tx_ready,
   input wire logic read_protect,
   input wire dcra_regport_type reg_port,
   input wire logic debug_halt_control_bit,
   input wire logic [7:0] debug_control_register
);
   default clocking @(posedge clk);
   endclocking
   default disable iff (!reset_n);
   sequence held_s;
      tx_valid && $stable(tx_data);
   endsequence
   tx_hold_a: assert property (tx_valid && !tx_ready |=> held_s)
      else $error("tx byte lost");
   wr_gate_a: assert property (reg_port.we |-> $past(debug_halt_control_bit))
      else $error("store outside debug");
   wr_prot_a: assert property (reg_port.we && $past(read_protect) |->
      reg_port.addr >= FLASH_CTL_LO && reg_port.addr <= FLASH_CTL_HI)
      else $error("protected store");
   halt_keep_a: assert property (read_protect && debug_halt_control_bit |=>
      debug_halt_control_bit)
      else $error("halt cleared");
   halt_bit_a: assert property (
      debug_halt_control_bit == debug_control_register[HALT_BIT])
      else $error("halt bit");
   addr_step_a: assert property (reg_port.we && $past(reg_port.we) |->
      reg_port.addr == 12'($past(reg_port.addr) + 12'h001))
      else $error("addr step");
   rd_busy_a: assert property (reg_port.re |-> !rx_ready)
      else $error("byte taken in read");
   re_pulse_a: assert property (reg_port.re |=> (!reg_port.re) [*2])
      else $error("read strobe");
endmodule : dcra_asserts
`default_nettype wire

// File: dcra_regfile_model.sv
// Register file behind the block.
// Read data appears the cycle after the strobe and holds until the next.
`timescale 1ns/100ps
`default_nettype none
module dcra_regfile_model
   import dcra_pkg::*;
(
   input wire logic clk,
   input wire dcra_regport_type reg_port,
   output logic [7:0] reg_rdata
);
   logic [7:0] mem [4096];
   initial
   begin
      foreach (mem[i])
         mem[i] = 8'h00;
      reg_rdata = 8'h5a;
   end
   always @(posedge clk)
   begin
      if (reg_port.we)
         mem[reg_port.addr] <= reg_port.data;
      if (reg_port.re)
         reg_rdata <= mem[reg_port.addr];
   end
endmodule : dcra_regfile_model
`default_nettype wire

// File: testbench.sv
// Self-checking bench for the debug register-access block.
// Plays the debugger; a register file model sits on the far side.
`timescale 1ns/100ps
`default_nettype none
module testbench;
   import dcra_pkg::*;
   logic clk, reset_n, rx_valid, rx_ready, tx_valid, tx_ready, read_protect, halt, dbg;
   logic [7:0] rx_data, tx_data, reg_rdata, ctl_reg;
   logic [15:0] pc_value;
   dcra_regport_type reg_port;
   logic [7:0] mem [4096];
   logic [31:0] rnd = 32'h87aa_39b1;
   int mismatches = 0;
   int n_tests = 0;
   dcra_debug_register_access dut (.clk(clk), .reset_n(reset_n), .rx_valid(rx_valid),
      .rx_data(rx_data), .rx_ready(rx_ready), .tx_valid(tx_valid), .tx_data(tx_data),
      .tx_ready(tx_ready), .read_protect(read_protect), .pc_value(pc_value),
      .reg_port(reg_port), .reg_rdata(reg_rdata), .debug_halt_control_bit(halt),
      .debug_control_register(ctl_reg));
   dcra_regfile_model rf (.clk(clk), .reg_port(reg_port), .reg_rdata(reg_rdata));
   initial
   begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr
   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : give_verdict
   task automatic bound(input int i);
      if (i >= 300)
      begin
         mismatches++;
         give_verdict();
      end
   endtask : bound
   task automatic send(input logic [7:0] b);
      int i;
      rx_valid = 1'b1;
      rx_data = b;
      for (i = 0; i < 300 && rx_ready !== 1'b1; i++)
         @(negedge clk);
      bound(i);
      @(negedge clk);
   endtask : send
   // Random stalls keep the two-entry buffer filling up
   task automatic recv(input logic [7:0] exp);
      int i;
      for (i = 0; i < 300; i++)
      begin
         rnd = lfsr(rnd);
         tx_ready = rnd[0] | rnd[1];
         if (tx_valid === 1'b1 && tx_ready)
            break;
         @(negedge clk);
      end
      bound(i);
      check("tx_data", tx_data, exp);
      @(negedge clk);
   endtask : recv
   task automatic ctl(input logic [7:0] v);
      send(OP_WR_CTL);
      send(v);
      dbg = v[7] | (read_protect & dbg);
      rx_valid = 1'b0;
      @(negedge clk);
      check("halt", {7'h00, halt}, {7'h00, dbg});
      check("ctl", ctl_reg, {dbg, v[6:0]});
   endtask : ctl
   task automatic pcrd();
      logic [15:0] e;
      e = (dbg && !read_protect) ? pc_value : PC_BLOCKED;
      send(OP_RD_PC);
      rx_valid = 1'b0;
      recv(e[15:8]);
      recv(e[7:0]);
   endtask : pcrd
   task automatic xfer(input logic rd, input logic [11:0] a, input logic [7:0] sz);
      logic [11:0] x;
      send(rd ? OP_RD_REG : OP_WR_REG);
      send({4'h0, a[11:8]});
      send(a[7:0]);
      send(sz);
      if (rd)
         rx_valid = 1'b0;
      for (int k = 0; k < ((sz == 8'h00) ? 256 : int'(sz)); k++)
      begin
         x = 12'(a + k);
         rnd = lfsr(rnd);
         if (rd)
            recv((dbg && !read_protect) ? mem[x] : BYTE_BLOCKED);
         else
            send(rnd[7:0]);
         if (!rd && dbg && (!read_protect || x >= 12'hff8))
            mem[x] = rnd[7:0];
      end
      rx_valid = 1'b0;
      @(negedge clk);
   endtask : xfer
   initial
   begin
      logic [11:0] a;
      logic [7:0] s;
      foreach (mem[i])
         mem[i] = 8'h00;
      {reset_n, rx_valid, tx_ready, read_protect, dbg, rx_data, pc_value} = '0;
      repeat (4) @(negedge clk);
      reset_n = 1'b1;
      pcrd();
      ctl(8'h80);
      for (int j = 0; j < 8; j++)
      begin
         rnd = lfsr(rnd);
         pc_value = rnd[31:16];
         a = rnd[11:0];
         s = {5'h00, rnd[14:12]} + 8'h01;
         pcrd();
         xfer(1'b0, a, s);
         xfer(1'b1, a, s);
      end
      xfer(1'b0, 12'hffe, 8'h00);
      xfer(1'b1, 12'hffe, 8'h00);
      ctl(8'h00);
      xfer(1'b0, 12'h020, 8'h02);
      xfer(1'b1, 12'h020, 8'h02);
      ctl(8'h80);
      xfer(1'b1, 12'h020, 8'h02);
      read_protect = 1'b1;
      xfer(1'b0, 12'hff6, 8'h04);
      xfer(1'b1, 12'hff6, 8'h04);
      pcrd();
      ctl(8'h00);
      read_protect = 1'b0;
      xfer(1'b1, 12'hff6, 8'h04);
      give_verdict();
   end
endmodule : testbench
bind dcra_debug_register_access dcra_asserts #(.FLASH_CTL_LO(FLASH_CTL_LO),
   .FLASH_CTL_HI(FLASH_CTL_HI)) chk (.clk(clk), .reset_n(reset_n), .rx_ready(rx_ready),
   .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready), .read_protect(read_protect),
   .reg_port(reg_port), .debug_halt_control_bit(debug_halt_control_bit),
   .debug_control_register(debug_control_register));
`default_nettype wire
